// ### src/idio_defines.vh
/*
 Constants for the isolated digital I/O port core: widths,
 filter timing and reset values. Included by the core only.
*/
`ifndef IDIO_DEFINES_VH
`define IDIO_DEFINES_VH

`define IDIO_CH 16
`define IDIO_OUT_RESET 16'h0000
`define IDIO_FILT_NS 1000
`define IDIO_CLK_NS 5
`define IDIO_FILT_CYC ((`IDIO_FILT_NS + `IDIO_CLK_NS - 1) / `IDIO_CLK_NS)
`define IDIO_FILT_W 8
`define IDIO_EDGE_FALL 1'b0
`define IDIO_EDGE_RISE 1'b1

`endif

// ### src/idio_port.v
/*
 Isolated digital I/O port core: 16 filtered inputs with edge
 interrupts, 16 outputs. Assumes a host-side bus adapter drives
 the plain control ports on the same clock; pins are asynchronous.
*/
// Behaviour
// - Sixteen inputs are each readable as one data bit and each can raise an interrupt.
// - Sixteen outputs are each driven from one bit the host writes.
// - All sixteen input interrupt requests merge into one interrupt line.
// - Each input interrupts on the pin edge the host selects, high-to-low or low-to-high.
// - Data is negative logic: data 0 is a high pin and data 1 a low pin, both ways.
// - A digital filter removes short noise and chatter before data and edge detection.
// - After reset every output is off until the host writes a new value.
// - An input reads 1 while its switch is closed and 0 while it is open.
`include "idio_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module idio_port (
	input wire clk,
	input wire rst,
	input wire [15:0] inPinLevel,
	output wire [15:0] outPinLevel,
	input wire outWrite,
	input wire [15:0] outWriteData,
	output wire [15:0] outData,
	output wire [15:0] inData,
	input wire [15:0] edgeSelect,
	input wire [15:0] irqEnable,
	input wire pendClear,
	input wire [15:0] pendClearMask,
	output wire [15:0] irqPending,
	output wire intA
);

	localparam integer FILT_CYC = `IDIO_FILT_CYC;
	localparam [`IDIO_FILT_W-1:0] FILT_MAX = FILT_CYC[`IDIO_FILT_W-1:0];

	wire [15:0] filtLevel;
	reg [15:0] filtLevelPrev_r;
	reg [15:0] outData_r;
	reg [15:0] outPinLevel_r;
	reg [15:0] pend_r;
	reg [15:0] pend_nxt;
	reg [15:0] edgeHit;
	reg intA_r;
	integer i;

	// One synchroniser and filter per pin
	// Costs 2 + window cycles of latency on every input
	genvar g;
	generate
		for (g = 0; g < `IDIO_CH; g = g + 1)
		begin : gen_in
			idio_in_filter #(
				.CNT_W(`IDIO_FILT_W),
				.CNT_MAX(FILT_MAX)
			) u_filt (
				.clk(clk),
				.rst(rst),
				.pinRaw(inPinLevel[g]),
				.levelOut(filtLevel[g])
			);
		end
	endgenerate

	// Previous level for edge detection
	always @(posedge clk)
	begin
		if (rst)
			filtLevelPrev_r <= 16'hFFFF;
		else
			filtLevelPrev_r <= filtLevel;
	end

	// One data bit per input channel
	// Low pin (switch closed) reads as 1
	assign inData = ~filtLevel;

	always @*
	begin
		for (i = 0; i < 16; i = i + 1)
		begin
			if (edgeSelect[i] == `IDIO_EDGE_RISE)
			begin
				edgeHit[i] = filtLevel[i] & ~filtLevelPrev_r[i];
			end
			else
			begin
				edgeHit[i] = ~filtLevel[i] & filtLevelPrev_r[i];
			end
		end
	end

	always @*
	begin
		pend_nxt = pend_r;
		if (pendClear)
			pend_nxt = pend_nxt & ~pendClearMask;
		pend_nxt = pend_nxt | (edgeHit & irqEnable);
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			pend_r <= 16'h0000;
			intA_r <= 1'b0;
		end
		else
		begin
			pend_r <= pend_nxt;
			intA_r <= |pend_nxt;
		end
	end

	assign irqPending = pend_r;
	assign intA = intA_r;

	always @(posedge clk)
	begin
		if (rst)
			outData_r <= `IDIO_OUT_RESET;
		else if (outWrite)
			outData_r <= outWriteData;
	end

	// Data 1 pulls the pin low
	// Own flop so the pin never sees a gate glitch
	always @(posedge clk)
	begin
		if (rst)
			outPinLevel_r <= ~`IDIO_OUT_RESET;
		else if (outWrite)
			outPinLevel_r <= ~outWriteData;
	end

	assign outData = outData_r;
	assign outPinLevel = outPinLevel_r;

endmodule

// Per-pin synchroniser and stable-time filter
module idio_in_filter #(
	parameter CNT_W = 8,
	parameter [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}}
) (
	input wire clk,
	input wire rst,
	input wire pinRaw,
	output wire levelOut
);

	reg sync1_r;
	reg sync2_r;
	reg level_r;
	reg level_nxt;
	reg [CNT_W-1:0] cnt_r;
	reg [CNT_W-1:0] cnt_nxt;

	// Pin is asynchronous; only sync2_r reads sync1_r
	always @(posedge clk)
	begin
		if (rst)
		begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end
		else
		begin
			sync1_r <= pinRaw;
			sync2_r <= sync1_r;
		end
	end

	// Level accepted only after holding the full window
	always @*
	begin
		cnt_nxt = cnt_r;
		level_nxt = level_r;
		if (sync2_r == level_r)
			cnt_nxt = {CNT_W{1'b0}};
		else if (cnt_r == CNT_MAX - 1'b1)
		begin
			cnt_nxt = {CNT_W{1'b0}};
			level_nxt = sync2_r;
		end
		else
			cnt_nxt = cnt_r + 1'b1;
	end

	// Idle pin is high, so reset high avoids a false edge
	always @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r <= {CNT_W{1'b0}};
			level_r <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			level_r <= level_nxt;
		end
	end

	assign levelOut = level_r;

endmodule

`default_nettype wire

// ### verification/idio_port_sva.sv
/* Output checker for idio_port.
 Assumes bind to the core, one clock. */
`timescale 1ns/1ps
`default_nettype none
module idio_port_sva(
	input wire clk,
	input wire rst,
	input wire outWrite,
	input wire pendClear,
	input wire intA,
	input wire [15:0] outWriteData,
	input wire [15:0] outData,
	input wire [15:0] outPinLevel,
	input wire [15:0] irqPending
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
AST_OUT_LOAD: assert property (outWrite |=> outData == $past(outWriteData)) else $error("out load");
AST_OUT_HOLD: assert property (!outWrite |=> $stable(outData)) else $error("out changed");
AST_PIN_NEG: assert property (outPinLevel == ~outData) else $error("pin polarity");
AST_INT_OR: assert property (intA == |irqPending) else $error("int merge");
AST_INT_HOLD: assert property (intA && !pendClear |=> intA) else $error("int dropped");
AST_RST_OFF: assert property ($fell(rst) |-> outData == 16'h0000 && !intA) else $error("reset");
cover property (outWrite);
cover property (intA);
cover property (pendClear && intA);
endmodule
bind idio_port idio_port_sva chk(.*);
`default_nettype wire

// ### verification/idio_port_tb_top.sv
/* Bench for idio_port.
 Assumes the switch model drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module idio_port_tb_top;
logic clk = 0, rst = 1, wr = 0, clr = 0;
logic [15:0] wd = 0, es = 0, cl = 0, gl = 0, msk = 16'hFFFF;
wire [15:0] pin, od, opl, id, pend;
wire ia;
integer failures = 0, checked = 0;
idio_switch sw(.closed(cl), .glitch(gl), .pinLevel(pin));
idio_port uut(.clk(clk), .rst(rst), .inPinLevel(pin), .outPinLevel(opl), .outWrite(wr), .outWriteData(wd),
	.outData(od), .inData(id), .edgeSelect(es), .irqEnable(16'hFFFF), .pendClear(clr),
	.pendClearMask(msk), .irqPending(pend), .intA(ia));
task chk(input string n, input [15:0] e, input [15:0] s);
	checked++;
	if (e !== s)
	begin
		failures++;
		$display("[ERR] %s exp %h got %h", n, e, s);
	end
endtask
task finish_test;
	$display("checked %0d failures %0d", checked, failures);
	if (failures == 0 && checked > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task t_out;
	@(negedge clk) chk("outData", 16'h0000, od);
	@(posedge clk) {wr, wd} <= {1'b1, 16'hA5C3};
	@(posedge clk) wr <= 0;
	@(negedge clk) chk("outData", 16'hA5C3, od);
	chk("outPin", 16'h5A3C, opl);
	$display("t_out done");
endtask
task t_in;
	// Short pulse must die in the filter
	@(posedge clk) gl <= 16'h0001;
	repeat (50) @(posedge clk);
	gl <= 16'h0000;
	repeat (210) @(posedge clk);
	@(negedge clk) chk("inData", 16'h0000, id);
	@(posedge clk) cl <= 16'h0001;
	repeat (210) @(posedge clk);
	@(negedge clk) chk("inData", 16'h0001, id);
	chk("pending", 16'h0001, pend);
	chk("intA", 16'h0001, ia);
	@(posedge clk) {clr, msk} <= {1'b1, 16'h0000};
	@(posedge clk) clr <= 0;
	@(negedge clk) chk("keptPend", 16'h0001, pend);
	chk("keptInt", 16'h0001, ia);
	@(posedge clk) {clr, msk} <= {1'b1, 16'hFFFF};
	@(posedge clk) {clr, es, cl} <= {1'b0, 16'hFFFF, 16'h0000};
	@(negedge clk) chk("intA", 16'h0000, ia);
	repeat (210) @(posedge clk);
	@(negedge clk) chk("pending", 16'h0001, pend);
	$display("t_in done");
endtask
initial forever #2.5 clk = ~clk;
initial
begin
	#20000 failures++;
	finish_test;
end
initial
begin
	repeat (20) @(posedge clk);
	rst <= 0;
	t_out;
	t_in;
	finish_test;
end
endmodule
`default_nettype wire

// ### verification/idio_switch.sv
/* Field switch bank on the input pins.
 Assumes a closed contact pulls its pin low. */
`timescale 1ns/1ps
`default_nettype none
module idio_switch(
	input wire [15:0] closed,
	input wire [15:0] glitch,
	output wire [15:0] pinLevel
);
assign pinLevel = ~(closed ^ glitch);
endmodule
`default_nettype wire
